// File: hdl/lasc_pkg.sv
package lasc_pkg;

  // ---------------------------------------------------------------------------
  // register byte offsets (one aligned word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LASC_ADDR_CTRL      = 8'h00; // mode control bits
  localparam logic [7:0] LASC_ADDR_CHOP      = 8'h04; // chopper config
  localparam logic [7:0] LASC_ADDR_VMIN      = 8'h08; // min adaptive velocity
  localparam logic [7:0] LASC_ADDR_TCOOL     = 8'h0c; // load ctrl velocity threshold
  localparam logic [7:0] LASC_ADDR_TQUIET    = 8'h10; // quiet chopper threshold
  localparam logic [7:0] LASC_ADDR_DCTUNE    = 8'h14; // pulse width and sensitivity
  localparam logic [7:0] LASC_ADDR_RAMP_VEL  = 8'h18; // ramp velocity
  localparam logic [7:0] LASC_ADDR_RAMP_STAT = 8'h1c; // status flags, read clears stop
  localparam logic [7:0] LASC_ADDR_LOAD      = 8'h20; // load measurement
  localparam logic [7:0] LASC_ADDR_MISSED    = 8'h24; // missed step counter
  localparam logic [7:0] LASC_ADDR_STATE     = 8'h28; // live state

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int LASC_CTRL_STOP_ON_STALL = 0;
  localparam int LASC_CTRL_QUIET_EN      = 1;
  localparam int LASC_CTRL_STEPDIR       = 2;
  localparam int LASC_CHOP_OFF_TIME_SETTING_LSB      = 0;
  localparam int LASC_CHOP_VHIGHFS       = 4;
  localparam int LASC_CHOP_VHIGHCHM      = 5;
  localparam int LASC_CHOP_BLANK_LSB     = 6;
  localparam int LASC_DCTUNE_SG_LSB      = 16;

  // ---------------------------------------------------------------------------
  // widths, limits, reset values and timing
  // ---------------------------------------------------------------------------
  localparam int          LASC_VEL_W      = 23;           // range up to 2^23-1
  localparam logic [3:0]  LASC_OFF_TIME_SETTING_CLAMP = 4'h8;         // 8..15 act as 8
  localparam logic [8:0]  LASC_LOAD_MAX   = 9'h1ff;       // up to 511
  localparam int          LASC_LONG_STEP_CYC = 1024;      // long step override
  localparam logic [3:0]  LASC_RST_OFF_TIME_SETTING   = 4'h3;
  localparam logic [9:0]  LASC_RST_DCTIME = 10'h000;
  localparam logic [7:0]  LASC_RST_DCSG   = 8'h00;
  localparam real         LASC_CLK_MHZ    = 100.0;

  // ---------------------------------------------------------------------------
  // packed carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       stepdir_mode;   // step/dir mode active
    logic       quiet_en;       // quiet voltage-mode chopper on
    logic       stop_on_stall_en;
  } lasc_ctrl_s;

  typedef struct packed {
    logic [1:0] blank_time_select;
    logic       vhighchm;
    logic       vhighfs;
    logic [3:0] off_time_setting;
  } lasc_chop_s;

  typedef struct packed {
    logic       const_off_slow; // constant off-time, slow decay only
    logic       fullstep;       // chopper in fullstep
    logic [3:0] eff_off_time;   // off time, clamped to 8 only while mode active
  } lasc_chop_out_s;

  typedef enum logic [1:0] {
    LASC_IDLE,
    LASC_RUN,
    LASC_WAIT,
    LASC_STOPPED
  } lasc_state_e;

endpackage

// File: hdl/lasc_core.sv
`timescale 1ns/10ps
module lasc_core
  import lasc_pkg::*;
#(
  parameter int LONG_STEP_CYC = LASC_LONG_STEP_CYC, // long pulse override length
  parameter int MISSED_W      = 16                  // missed step counter width
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // step/dir pins
  input  wire logic                  step_in,
  input  wire logic                  dir_in,
  input  wire logic                  adaptive_enable_in,
  input  wire logic                  adaptive_wait_in,
  output logic                       step_ready_out,
  // motor side
  input  wire logic [LASC_VEL_W-1:0] ramp_target,     // ramp generator target
  input  wire logic [LASC_VEL_W-1:0] motor_velocity,  // current velocity
  input  wire logic [LASC_VEL_W-1:0] step_velocity,   // step/dir velocity
  input  wire logic                  stall_detect,    // raw stall from load meas
  input  wire logic [8:0]            load_value,      // load measurement
  input  wire logic                  step_taken,      // mechanical step done
  input  wire logic [3:0]            microstep_resolution, // log2 microsteps per full
  input  wire logic                  min_vel_tick,    // minimum velocity pacing tick
  output logic                       adaptive_active,
  output lasc_chop_out_s             chop_out,
  output logic                       motor_step,      // step to sequencer
  output logic                       motor_dir,
  output logic      [9:0]            load_ref_pulse_width,
  output logic      [7:0]            adaptive_stall_sensitivity
);

  initial begin
    if (LONG_STEP_CYC < 1 || LONG_STEP_CYC > 65535) $error("LONG_STEP_CYC out of range");
    if (MISSED_W < 2 || MISSED_W > 32) $error("MISSED_W out of range");
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  lasc_ctrl_s                ctrl;              // control bits
  lasc_chop_s                chopper_config;    // chopper config
  logic [LASC_VEL_W-1:0]     min_adaptive_velocity;
  logic [LASC_VEL_W-1:0]     load_ctrl_velocity_threshold;
  logic [LASC_VEL_W-1:0]     quiet_chopper_velocity_threshold;
  logic [LASC_VEL_W-1:0]     ramp_velocity;     // reported velocity
  logic                      stall_stop_flag;   // active stop condition
  logic [8:0]                load_result;       // captured load
  logic [MISSED_W-1:0]       missed_steps;      // missed step counter
  lasc_state_e               state;             // step machine state
  lasc_state_e               next_state;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] pin_s1;   // first stage, read by second only
  logic [3:0] pin_s2;   // safe copies
  logic       step_d;   // step level delayed for edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      step_d <= 1'b0;
    end else begin
      pin_s1 <= {adaptive_wait_in, adaptive_enable_in, dir_in, step_in};
      pin_s2 <= pin_s1;
      step_d <= pin_s2[0];
    end
  end
  wire logic step_s  = pin_s2[0];
  wire logic dir_s   = pin_s2[1];
  wire logic en_s    = pin_s2[2];
  wire logic wait_s  = pin_s2[3];
  wire logic step_rise = step_s & ~step_d;

  // ---------------------------------------------------------------------------
  // ahb-lite address phase capture
  // ---------------------------------------------------------------------------
  logic       dp_valid;  // data phase pending
  logic       dp_write;
  logic [7:0] dp_addr;
  wire  logic ap_take = hsel & hready & htrans[1];
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_valid <= ap_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;   // zero wait states
  assign hresp     = 1'b0;   // always okay
  wire logic wr_en = dp_valid & dp_write;
  // status clears at the end of its read data phase, so the read still returns the flag
  wire logic rd_stat = dp_valid & ~dp_write & (dp_addr == LASC_ADDR_RAMP_STAT);

  // ---------------------------------------------------------------------------
  // mode decision
  // ---------------------------------------------------------------------------
  wire logic flags_ok  = chopper_config.vhighfs & chopper_config.vhighchm;
  wire logic vmin_on   = (min_adaptive_velocity != '0);
  wire logic above_min = vmin_on & (motor_velocity > min_adaptive_velocity);
  wire logic quiet_blk = ctrl.quiet_en & (step_velocity < quiet_chopper_velocity_threshold);
  wire logic pin_force = ctrl.stepdir_mode & en_s;
  wire logic mode_req  = pin_force | (flags_ok & above_min);
  wire logic next_active = mode_req & ~quiet_blk & ~(ctrl.quiet_en & ~pin_force);
  wire logic stall_ok  = stall_detect & (motor_velocity <= load_ctrl_velocity_threshold);

  // ---------------------------------------------------------------------------
  // chopper outputs
  // ---------------------------------------------------------------------------
  wire logic [3:0] off_time_setting_eff = (chopper_config.off_time_setting >= LASC_OFF_TIME_SETTING_CLAMP) ?
                              LASC_OFF_TIME_SETTING_CLAMP : chopper_config.off_time_setting;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      adaptive_active <= 1'b0;
      chop_out        <= '0;
    end else begin
      adaptive_active         <= next_active;
      chop_out.fullstep       <= next_active;
      chop_out.const_off_slow <= next_active;
      chop_out.eff_off_time   <= next_active ? off_time_setting_eff
                                             : chopper_config.off_time_setting;
    end
  end

  // ---------------------------------------------------------------------------
  // stall stop, status flag and ramp velocity
  // ---------------------------------------------------------------------------
  wire logic stall_set = ctrl.stop_on_stall_en & adaptive_active & stall_ok;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stall_stop_flag <= 1'b0;
      ramp_velocity   <= '0;
      load_result     <= 9'h000;
    end else begin
      if (stall_set)
        stall_stop_flag <= 1'b1;
      else if (rd_stat)
        stall_stop_flag <= 1'b0;
      ramp_velocity <= (stall_set | stall_stop_flag) ? '0 : ramp_target;
      if (adaptive_active)
        load_result <= load_value & LASC_LOAD_MAX;
    end
  end

  // ---------------------------------------------------------------------------
  // step buffering and long pulse override
  // ---------------------------------------------------------------------------
  logic [8:0]  pend;       // buffered microsteps
  logic [15:0] hold_cnt;   // step high duration
  logic        forced;     // override already issued for this pulse
  wire  logic [8:0] buf_max = 9'((9'h1 << microstep_resolution) - 9'h1);
  wire  logic long_pulse = step_s & (hold_cnt >= 16'(LONG_STEP_CYC - 1)) & ~forced;
  wire  logic halt = stall_stop_flag;
  wire  logic blocked = adaptive_active & (~step_taken | ~wait_s);
  wire  logic can_go  = ~halt & (~adaptive_active | ~blocked | long_pulse | min_vel_tick);
  wire  logic have    = (pend != 9'h000) | step_rise;
  wire  logic issue   = have & can_go;
  wire  logic lose    = step_rise & ~issue & (pend >= buf_max) & adaptive_active;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt <= 16'h0000;
      forced   <= 1'b0;
    end else begin
      hold_cnt <= step_s ? ((hold_cnt == 16'hffff) ? hold_cnt : hold_cnt + 16'h1) : 16'h0000;
      forced   <= step_s & (forced | long_pulse);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend         <= 9'h000;
      motor_step   <= 1'b0;
      motor_dir    <= 1'b0;
      missed_steps <= '0;
    end else begin
      motor_step <= issue;
      motor_dir  <= dir_s;
      if (step_rise & ~issue & ~lose)
        pend <= pend + 9'h1;
      else if (issue & ~step_rise & (pend != 9'h000))
        pend <= pend - 9'h1;
      if (lose)
        missed_steps <= dir_s ? missed_steps + 1'b1 : missed_steps - 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // state and ready
  // ---------------------------------------------------------------------------
  always_comb begin
    case (state)
      LASC_IDLE:    next_state = next_active ? LASC_RUN : LASC_IDLE;
      LASC_RUN:     next_state = halt ? LASC_STOPPED : (blocked ? LASC_WAIT : LASC_RUN);
      LASC_WAIT:    next_state = halt ? LASC_STOPPED : (blocked ? LASC_WAIT : LASC_RUN);
      LASC_STOPPED: next_state = halt ? LASC_STOPPED : LASC_IDLE;
      default:      next_state = LASC_IDLE;
    endcase
    if (!next_active && !halt)
      next_state = LASC_IDLE;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      state <= LASC_IDLE;
    else
      state <= next_state;
  end
  // ready low on block, wait pin or stall stop while mode active; high otherwise
  assign step_ready_out = ~(adaptive_active & (blocked | halt));

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl                             <= '0;
      chopper_config                   <= '{blank_time_select: 2'h0, vhighchm: 1'b0,
                                            vhighfs: 1'b0, off_time_setting: LASC_RST_OFF_TIME_SETTING};
      min_adaptive_velocity            <= '0;
      load_ctrl_velocity_threshold     <= '0;
      quiet_chopper_velocity_threshold <= '0;
      load_ref_pulse_width             <= LASC_RST_DCTIME;
      adaptive_stall_sensitivity       <= LASC_RST_DCSG;
    end else if (wr_en) begin
      case (dp_addr)
        LASC_ADDR_CTRL:   ctrl <= lasc_ctrl_s'(hwdata[2:0]);
        LASC_ADDR_CHOP:   chopper_config <= lasc_chop_s'(hwdata[7:0]);
        LASC_ADDR_VMIN:   min_adaptive_velocity <= hwdata[LASC_VEL_W-1:0];
        LASC_ADDR_TCOOL:  load_ctrl_velocity_threshold <= hwdata[LASC_VEL_W-1:0];
        LASC_ADDR_TQUIET: quiet_chopper_velocity_threshold <= hwdata[LASC_VEL_W-1:0];
        LASC_ADDR_DCTUNE: begin
          load_ref_pulse_width       <= hwdata[9:0];
          adaptive_stall_sensitivity <= hwdata[LASC_DCTUNE_SG_LSB +: 8];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  logic [31:0] rd_word;
  always_comb begin
    case (dp_addr)
      LASC_ADDR_CTRL:      rd_word = {29'h0, ctrl};
      LASC_ADDR_CHOP:      rd_word = {24'h0, chopper_config};
      LASC_ADDR_VMIN:      rd_word = {9'h0, min_adaptive_velocity};
      LASC_ADDR_TCOOL:     rd_word = {9'h0, load_ctrl_velocity_threshold};
      LASC_ADDR_TQUIET:    rd_word = {9'h0, quiet_chopper_velocity_threshold};
      LASC_ADDR_DCTUNE:    rd_word = {8'h0, adaptive_stall_sensitivity, 6'h0, load_ref_pulse_width};
      LASC_ADDR_RAMP_VEL:  rd_word = {9'h0, ramp_velocity};
      LASC_ADDR_RAMP_STAT: rd_word = {31'h0, stall_stop_flag};
      LASC_ADDR_LOAD:      rd_word = {23'h0, load_result};
      LASC_ADDR_MISSED:    rd_word = 32'(missed_steps);
      LASC_ADDR_STATE:     rd_word = {27'h0, pend == 9'h000, adaptive_active, step_ready_out, state};
      default:             rd_word = 32'h0000_0000;
    endcase
  end
  assign hrdata = (dp_valid & ~dp_write) ? rd_word : 32'h0000_0000;

endmodule

// File: verification/lasc_step_model.sv
`timescale 1ns/10ps
// external step/dir controller: bursts of step pulses
module lasc_step_model (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        step_ready_out, // high when a step may follow
  input  wire logic        start,          // begin a burst
  input  wire logic [7:0]  n_steps,        // pulses in the burst
  input  wire logic [11:0] high_len,       // cycles each pulse stays high
  input  wire logic        obey,           // honour step_ready_out
  output logic             step_in,
  output logic             busy
);
  logic [7:0]  left;                       // pulses still to send
  logic [11:0] cnt;                        // cycles in current level
  // low gap of at least five cycles lets the synchroniser see every edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      left    <= 8'h00;
      cnt     <= 12'h000;
      step_in <= 1'b0;
      busy    <= 1'b0;
    end else if (start) begin
      left <= n_steps;
      cnt  <= 12'h000;
      busy <= 1'b1;
    end else if (step_in) begin
      cnt <= cnt + 12'h001;
      if (cnt == high_len - 12'h001) begin
        step_in <= 1'b0;
        cnt     <= 12'h000;
        left    <= left - 8'h01;
      end
    end else if (busy && cnt >= 12'h004) begin
      if (left == 8'h00) begin
        busy <= 1'b0;
      end else if (!obey || step_ready_out) begin
        step_in <= 1'b1;
        cnt     <= 12'h000;
      end
    end else begin
      cnt <= cnt + 12'h001;
    end
  end
endmodule

// File: verification/lasc_core_checker.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// port checker for the adaptive step core
// -----------------------------------------------------------------------------
module lasc_core_checker
  import lasc_pkg::*;
#(
  parameter int LONG_STEP_CYC = LASC_LONG_STEP_CYC
) (
  input wire logic           clk_sys,
  input wire logic           arst_n,
  input wire logic           hsel,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic           hready,
  input wire logic [31:0]    hrdata,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire logic           step_in,
  input wire logic           adaptive_wait_in,
  input wire logic           min_vel_tick,
  input wire logic           step_ready_out,
  input wire logic           adaptive_active,
  input wire lasc_chop_out_s chop_out,
  input wire logic           motor_step
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic rd_dp;     // read data phase in progress
  int   hi_cnt;    // cycles step_in has been high
  logic step_seen; // a step was issued during this pulse
  // helper state tracking bus phase and pulse length
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_dp     <= 1'b0;
      hi_cnt    <= 0;
      step_seen <= 1'b0;
    end else begin
      rd_dp     <= hsel & hready & htrans[1] & !hwrite;
      hi_cnt    <= step_in ? ((hi_cnt < 4000) ? hi_cnt + 1 : hi_cnt) : 0;
      step_seen <= step_in & (step_seen | motor_step);
    end
  end
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_no_wait_state: assert property (hreadyout == 1'b1) else $error("wait state seen");
  a_idle_rdata_zero: assert property (!rd_dp |-> hrdata == 32'h0) else $error("rdata outside read");
  a_ready_when_off: assert property (!adaptive_active |-> step_ready_out)
    else $error("ready low while mode off");
  a_wait_ready_low: assert property ((!adaptive_wait_in && adaptive_active) [*4] |-> !step_ready_out)
    else $error("ready high while wait low");
  a_wait_no_step: assert property ((!adaptive_wait_in && adaptive_active && !step_in && !min_vel_tick) [*5]
    |-> !motor_step)
    else $error("step issued while wait low");
  a_off_time_clamp: assert property (adaptive_active && $past(adaptive_active, 2)
    |-> chop_out.eff_off_time <= LASC_OFF_TIME_SETTING_CLAMP)
    else $error("off time above clamp");
  a_slow_decay_on: assert property (adaptive_active && $past(adaptive_active, 2)
    |-> chop_out.const_off_slow)
    else $error("slow decay not forced");
  a_long_pulse_step: assert property (hi_cnt == LONG_STEP_CYC + 6 |-> step_seen)
    else $error("long pulse forced no step");
  c_read_phase: cover property (rd_dp);
  c_ready_drop: cover property ($fell(step_ready_out));
  c_long_pulse: cover property (hi_cnt == LONG_STEP_CYC + 6);
  c_fullstep: cover property (adaptive_active && chop_out.fullstep);
endmodule
bind lasc_core lasc_core_checker #(.LONG_STEP_CYC(LONG_STEP_CYC)) chk_u (
  .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .step_in(step_in),
  .adaptive_wait_in(adaptive_wait_in), .min_vel_tick(min_vel_tick), .step_ready_out(step_ready_out),
  .adaptive_active(adaptive_active), .chop_out(chop_out), .motor_step(motor_step));

// File: verification/load_adaptive_step_control_test.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// testbench for the adaptive step core
// -----------------------------------------------------------------------------
module load_adaptive_step_control_test
  import lasc_pkg::*;
;
  logic           clk_sys, arst_n, hwrite, hreadyout, hresp, step_in, dir_in;
  logic           adaptive_enable_in, adaptive_wait_in, step_ready_out, stall_detect;
  logic           step_taken, min_vel_tick, adaptive_active, motor_step, motor_dir;
  logic           p_start, p_obey, p_busy;  // partner controls
  logic [31:0]    haddr, hwdata, hrdata, rd;
  logic [1:0]     htrans;
  logic [22:0]    ramp_target, motor_velocity, step_velocity;
  logic [8:0]     load_value;
  logic [3:0]     microstep_resolution;
  logic [9:0]     pulse_w;
  logic [7:0]     sens, p_n;
  logic [11:0]    p_len;
  lasc_chop_out_s chop_out;
  int             n_errors, checks, cycles, steps, s0;
  lasc_core #(.LONG_STEP_CYC(8), .MISSED_W(16)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .step_in(step_in), .dir_in(dir_in),
    .adaptive_enable_in(adaptive_enable_in), .adaptive_wait_in(adaptive_wait_in),
    .step_ready_out(step_ready_out), .ramp_target(ramp_target), .motor_velocity(motor_velocity),
    .step_velocity(step_velocity), .stall_detect(stall_detect), .load_value(load_value),
    .step_taken(step_taken), .microstep_resolution(microstep_resolution),
    .min_vel_tick(min_vel_tick), .adaptive_active(adaptive_active), .chop_out(chop_out),
    .motor_step(motor_step), .motor_dir(motor_dir), .load_ref_pulse_width(pulse_w),
    .adaptive_stall_sensitivity(sens));
  lasc_step_model ctl_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .step_ready_out(step_ready_out), .start(p_start),
    .n_steps(p_n), .high_len(p_len), .obey(p_obey), .step_in(step_in), .busy(p_busy));
  // free running clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // cycle count, step count and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (motor_step === 1'b1) steps++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask
  // one ahb single transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask
  // partner burst: n pulses of len cycles
  task automatic burst(input logic [7:0] n, input logic [11:0] len, input logic obey);
    p_n     <= n;
    p_len   <= len;
    p_obey  <= obey;
    p_start <= 1'b1;
    @(posedge clk_sys);
    p_start <= 1'b0;
    @(posedge clk_sys);
    while (p_busy === 1'b1) @(posedge clk_sys);
  endtask
  initial begin
    {arst_n, hwrite, dir_in, adaptive_enable_in, stall_detect, min_vel_tick, p_start, p_obey} = '0;
    {haddr, hwdata, htrans, ramp_target, motor_velocity, step_velocity, load_value, p_n} = '0;
    {adaptive_wait_in, step_taken, p_len} = {2'b11, 12'h003};
    microstep_resolution = 4'h2;
    {n_errors, checks, cycles, steps} = '0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(LASC_ADDR_CHOP, 32'h3);
    rd_chk(8'h40, 32'h0);
    bus(1'b1, LASC_ADDR_DCTUNE, 32'h00ab03ff);
    rd_chk(LASC_ADDR_DCTUNE, 32'h00ab03ff);
    check({14'h0, sens, pulse_w}, 32'h0002afff);
    load_value <= 9'h1ff;
    ramp_target    <= 23'h1234;
    motor_velocity <= 23'h100;
    step_velocity  <= 23'h100;
    adaptive_enable_in <= 1'b1;
    bus(1'b1, LASC_ADDR_VMIN, 32'h10);
    bus(1'b1, LASC_ADDR_TCOOL, 32'h200);
    bus(1'b1, LASC_ADDR_CHOP, 32'h3c);
    bus(1'b1, LASC_ADDR_CTRL, 32'h5);
    settle();
    check({31'h0, adaptive_active}, 32'h1);
    check({26'h0, chop_out}, {26'h0, 2'b11, LASC_OFF_TIME_SETTING_CLAMP});
    rd_chk(LASC_ADDR_RAMP_VEL, 32'h1234);
    rd_chk(LASC_ADDR_LOAD, 32'h1ff);
    stall_detect <= 1'b1;
    settle();
    stall_detect <= 1'b0;
    settle();
    rd_chk(LASC_ADDR_RAMP_VEL, 32'h0);
    rd_chk(LASC_ADDR_RAMP_STAT, 32'h1);
    settle();
    rd_chk(LASC_ADDR_RAMP_STAT, 32'h0);
    rd_chk(LASC_ADDR_RAMP_VEL, 32'h1234);
    adaptive_wait_in <= 1'b0;
    settle();
    check({31'h0, step_ready_out}, 32'h0);
    adaptive_wait_in <= 1'b1;
    settle();
    check({31'h0, step_ready_out}, 32'h1);
    step_taken <= 1'b0;
    dir_in     <= 1'b1;
    burst(8'd6, 12'd3, 1'b0);
    settle();
    check({31'h0, step_ready_out}, 32'h0);
    rd_chk(LASC_ADDR_MISSED, 32'h3);
    dir_in <= 1'b0;
    burst(8'd2, 12'd3, 1'b0);
    rd_chk(LASC_ADDR_MISSED, 32'h1);
    s0 = steps;
    min_vel_tick <= 1'b1;
    @(posedge clk_sys);
    min_vel_tick <= 1'b0;
    settle();
    check({31'h0, steps > s0}, 32'h1);
    s0 = steps;
    burst(8'd1, 12'd16, 1'b0);
    settle();
    check({31'h0, steps > s0}, 32'h1);
    step_taken <= 1'b1;
    bus(1'b1, LASC_ADDR_TQUIET, 32'h7fffff);
    bus(1'b1, LASC_ADDR_CTRL, 32'h7);
    settle();
    check({31'h0, adaptive_active}, 32'h0);
    adaptive_enable_in <= 1'b0;
    bus(1'b1, LASC_ADDR_CTRL, 32'h5);
    bus(1'b1, LASC_ADDR_VMIN, 32'h0);
    settle();
    check({31'h0, adaptive_active}, 32'h0);
    print_verdict();
  end
endmodule
